// File: verilog/crs_pkg.sv
// Constants and types for the clock/reset sequencer.
// Assumes one 25 MHz oscillator clock; registers sit behind 32-bit APB.
package crs_pkg;

	// ----------------------------------------
	// Sequence timing, in oscillator cycles
	// ----------------------------------------
	localparam int unsigned CLK_MHZ   = 25;
	localparam int unsigned DRIVE_CYC = 516;
	localparam int unsigned WAIT_CYC  = 256;
	localparam int unsigned SEQ_CYC   = 768;
	localparam int unsigned CNT_W     = 10;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int unsigned ADDR_W     = 8;
	localparam logic [7:0]  IDX_TEST0  = 8'h3a;
	localparam logic [7:0]  IDX_TEST1  = 8'h3b;
	localparam logic [7:0]  ADDR_TEST0 = 8'(IDX_TEST0 * 4);
	localparam logic [7:0]  ADDR_TEST1 = 8'(IDX_TEST1 * 4);
	localparam logic [7:0]  ADDR_CTL   = 8'h00;
	localparam logic [7:0]  ADDR_FLG   = 8'h04;
	localparam logic [7:0]  ADDR_MASK  = 8'h08;
	localparam logic [7:0]  ADDR_VEC   = 8'h0c;

	localparam int unsigned CTL_OSC_ENABLE    = 0;
	localparam int unsigned FLG_FREQ_LOCK_STATUS   = 8;
	localparam int unsigned FLG_UPOSC    = 9;
	localparam int unsigned EVT_W        = 5;
	localparam logic [4:0]  EVT_RST      = 5'h02;
	localparam logic [4:0]  MASK_RST     = 5'h00;
	localparam logic [7:0]  TEST0_VAL    = 8'h00;
	// Arbitrary constant for the undefined test register
	localparam logic [7:0]  TEST1_VAL    = 8'h5a;
	localparam logic [31:0] ZERO32       = 32'h0000_0000;

	// Sticky event flags, one bit each, same layout as the mask
	typedef struct packed {
		logic osc_fail;
		logic wdog;
		logic illegal;
		logic por;
		logic lock_chg;
	} crs_evt_type;

	typedef enum logic [1:0] {
		VEC_POR,
		VEC_OSC,
		VEC_WDOG
	} crs_vec_type;

	typedef struct packed {
		logic              sel;
		logic              en;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
	} crs_apb_type;

endpackage : crs_pkg

// File: verilog/crs_sequencer.sv
// Reset sequencer, lock-change interrupt and oscillator enable.
// Assumes inputs synchronous to clk; reset pin is open drain outside.
//
// Function
// RQ1: First test register reads zero, ignores all writes.
// RQ2: Power-on, pin low, illegal access, watchdog, oscillator fail start a reset.
// RQ3: Enabled oscillator losing clock or running slow raises a monitor reset.
// RQ4: Reset pin is driven low 516 cycles, then released.
// RQ5: Entry needs no running clock; progress only on clock edges; code enters only on a clock edge (srst is synchronous).
// RQ6: 256 cycles after release, the pin level is sampled.
// RQ7: Pin high: oscillator fail vector, else watchdog, else power-on vector.
// RQ8: Internal reset holds 768 cycles, longer while pin held low; code holds 772 (516 drive + 256 wait).
// RQ9: Watchdog timeout enters reset.
// RQ10: Any lock status change requests the lock interrupt.
// RQ11: Lock request gated by its enable and the global mask.
// RQ12: Lock change flag set on change, cleared by writing one.
// RQ13: Oscillator off when enable is zero, Pierce mode when one.
// RQ14: Board keeps pin capacitance low so it rises within 256 cycles.
// RQ15: Stop entry or config writes clear lock status, no flag.
// RQ16: Power-on flag set at power-on, cleared only by writing one.
// RQ17: Pin synchronised before use; pendings cleared after vector choice.
// RQ18: Second test register takes no writes, reads a constant.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module crs_sequencer
	import crs_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	input  wire logic              por_det,
	input  wire logic              illegal_acc,
	input  wire logic              wdog_timeout,
	input  wire logic              osc_clk_lost,
	input  wire logic              osc_freq_low,
	input  wire logic              osc_started,
	input  wire logic              lock_det,
	input  wire logic              stop_entry,
	input  wire logic              loop_cfg_wr,
	input  wire logic              cpu_irq_mask,
	input  wire logic              rst_pin_in,
	output var  logic              rst_pin_out,
	output var  logic              rst_pin_oe,
	output var  logic              sys_rst,
	output var  logic [1:0]        vec_sel,
	output var  logic              vec_valid,
	output var  logic              osc_enable,
	output var  logic              irq
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DRIVE,
		ST_WAIT,
		ST_HOLD
	} crs_state_type;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	crs_apb_type req;
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic [31:0] rd_data;
	logic        hit;

	assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata};

	wire acc_go  = req.sel && req.en && !pready_r;
	wire wr_done = req.sel && req.en && pready_r && req.wr && !pslverr_r;
	wire wr_ctl  = wr_done && (req.addr == ADDR_CTL);
	wire wr_flg  = wr_done && (req.addr == ADDR_FLG);
	wire wr_mask = wr_done && (req.addr == ADDR_MASK);

	// ----------------------------------------
	// Control, flags, lock tracking
	// ----------------------------------------
	crs_evt_type    flg_r;
	crs_evt_type    flg_nxt;
	crs_evt_type    evt;
	logic [4:0]     mask_r;
	logic           osc_en_r;
	logic           freq_lock_status_r;
	logic           irq_r;
	crs_state_type  state_r;
	crs_state_type  state_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic           pin_meta_r;
	logic           pin_sync_r;
	logic           wdog_pend_r;
	logic           osc_pend_r;
	logic           oe_r;
	logic           sysrst_r;
	crs_vec_type    vec_r;
	logic           vec_valid_r;

	wire osc_fail  = osc_en_r && osc_started && (osc_clk_lost || osc_freq_low); // RQ3
	wire lock_clr  = stop_entry || loop_cfg_wr || wr_ctl; // RQ15
	wire lock_chg  = !lock_clr && (lock_det != freq_lock_status_r); // RQ10
	wire pin_low   = !pin_sync_r;
	wire rst_evt   = por_det || illegal_acc || wdog_timeout || osc_fail; // RQ2 RQ9
	wire seq_start = (state_r == ST_IDLE) && (rst_evt || pin_low); // RQ2
	wire drive_end = (state_r == ST_DRIVE) && (cnt_r == CNT_W'(DRIVE_CYC - 1));
	wire wait_end  = (state_r == ST_WAIT) && (cnt_r == CNT_W'(WAIT_CYC - 1)); // RQ6

	assign evt = '{osc_fail: osc_fail, wdog: wdog_timeout, illegal: illegal_acc,
		por: por_det, lock_chg: lock_chg};

	// Set wins over a write-one clear in the same cycle
	assign flg_nxt = evt | (flg_r & ~(wr_flg ? pwdata[EVT_W-1:0] : 5'h00)); // RQ12 RQ16

	assign rd_data =
		(req.addr == ADDR_CTL)   ? {31'h0000_0000, osc_en_r} :
		(req.addr == ADDR_FLG)   ? {22'h00_0000, osc_started, freq_lock_status_r, 3'h0, flg_r} :
		(req.addr == ADDR_MASK)  ? {27'h000_0000, mask_r} :
		(req.addr == ADDR_VEC)   ? {30'h0000_0000, vec_r} :
		(req.addr == ADDR_TEST0) ? {24'h00_0000, TEST0_VAL} : // RQ1
		(req.addr == ADDR_TEST1) ? {24'h00_0000, TEST1_VAL} : // RQ18
		ZERO32;
	assign hit = (req.addr == ADDR_CTL) || (req.addr == ADDR_FLG) ||
		(req.addr == ADDR_MASK) || (req.addr == ADDR_VEC) ||
		(req.addr == ADDR_TEST0) || (req.addr == ADDR_TEST1);

	// One wait state; test registers have no write path at all
	always_ff @(posedge clk) begin
		if (srst) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= ZERO32;
		end else begin
			pready_r  <= acc_go;
			pslverr_r <= acc_go && !hit;
			if (acc_go && !req.wr) begin
				prdata_r <= rd_data; // RQ1 RQ18
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			flg_r    <= EVT_RST; // RQ16
			mask_r   <= MASK_RST;
			osc_en_r <= 1'b0;
			freq_lock_status_r <= 1'b0;
			irq_r    <= 1'b0;
		end else begin
			flg_r    <= flg_nxt;
			if (wr_mask) begin
				mask_r <= pwdata[EVT_W-1:0];
			end
			if (wr_ctl) begin
				osc_en_r <= pwdata[CTL_OSC_ENABLE]; // RQ13
			end
			freq_lock_status_r <= lock_clr ? 1'b0 : lock_det; // RQ15
			irq_r    <= (|(flg_r & mask_r)) && !cpu_irq_mask; // RQ11
		end
	end

	// ----------------------------------------
	// Reset sequencer
	// ----------------------------------------
	// Pin synchroniser; only the second stage is looked at
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_meta_r <= 1'b1;
			pin_sync_r <= 1'b1;
		end else begin
			pin_meta_r <= rst_pin_in; // RQ17
			pin_sync_r <= pin_meta_r;
		end
	end

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r + CNT_W'(1);
		case (state_r)
			ST_IDLE: begin
				cnt_nxt = '0;
				if (seq_start) begin
					state_nxt = ST_DRIVE;
				end
			end
			ST_DRIVE: begin
				if (drive_end) begin // RQ4
					state_nxt = ST_WAIT;
					cnt_nxt   = '0;
				end
			end
			ST_WAIT: begin
				if (wait_end) begin
					state_nxt = pin_low ? ST_HOLD : ST_IDLE; // RQ8
					cnt_nxt   = '0;
				end
			end
			ST_HOLD: begin
				cnt_nxt = '0;
				if (!pin_low) begin
					state_nxt = ST_IDLE; // RQ8
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				cnt_nxt   = '0;
			end
		endcase
	end

	// Sync reset only: a stopped clock freezes the sequence where it is
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r     <= ST_DRIVE; // RQ5
			cnt_r       <= '0;
			oe_r        <= 1'b1;
			sysrst_r    <= 1'b1;
			vec_r       <= VEC_POR;
			vec_valid_r <= 1'b0;
			wdog_pend_r <= 1'b0;
			osc_pend_r  <= 1'b0;
		end else begin
			state_r     <= state_nxt; // RQ5
			cnt_r       <= cnt_nxt;
			oe_r        <= (state_nxt == ST_DRIVE); // RQ4
			sysrst_r    <= (state_nxt != ST_IDLE); // RQ8
			vec_valid_r <= wait_end;
			if (wait_end) begin
				if (!pin_low && osc_pend_r) begin // RQ7
					vec_r <= VEC_OSC;
				end else if (!pin_low && wdog_pend_r) begin
					vec_r <= VEC_WDOG;
				end else begin
					vec_r <= VEC_POR;
				end
			end
			// Cleared after the choice unless a new event lands now
			wdog_pend_r <= wdog_timeout || (wdog_pend_r && !wait_end); // RQ17 RQ9
			osc_pend_r  <= osc_fail || (osc_pend_r && !wait_end); // RQ17 RQ3
		end
	end

	assign prdata      = prdata_r;
	assign pready      = pready_r;
	assign pslverr     = pslverr_r;
	assign rst_pin_out = 1'b0;
	assign rst_pin_oe  = oe_r;
	assign sys_rst     = sysrst_r;
	assign vec_sel     = vec_r;
	assign vec_valid   = vec_valid_r;
	assign osc_enable  = osc_en_r;
	assign irq         = irq_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [CNT_W-1:0] low_len_r;
	logic [CNT_W-1:0] rel_len_r;
	always_ff @(posedge clk) begin
		if (srst) begin
			low_len_r <= '0;
			rel_len_r <= '0;
		end else begin
			low_len_r <= oe_r ? low_len_r + CNT_W'(1) : '0;
			rel_len_r <= oe_r ? '0 : rel_len_r + CNT_W'(1);
		end
	end

	test0_zero_a: assert property (@(posedge clk) disable iff (srst) // RQ1
		pready && !pwrite && paddr == ADDR_TEST0 |-> prdata == ZERO32)
		else $error("test register 0 not zero");
	start_evt_a: assert property (@(posedge clk) disable iff (srst) // RQ2
		state_r == ST_IDLE && (wdog_timeout || illegal_acc) |=> rst_pin_oe ##1 sys_rst)
		else $error("reset event did not start sequence");
	osc_fail_a: assert property (@(posedge clk) disable iff (srst) // RQ3
		osc_fail && state_r == ST_IDLE |=> rst_pin_oe && osc_pend_r)
		else $error("oscillator failure ignored");
	low_len_a: assert property (@(posedge clk) disable iff (srst) // RQ4
		$fell(rst_pin_oe) |-> $past(low_len_r) == CNT_W'(DRIVE_CYC - 1))
		else $error("pin low drive length wrong");
	sample_time_a: assert property (@(posedge clk) disable iff (srst) // RQ6
		vec_valid |-> rel_len_r == CNT_W'(WAIT_CYC) && $past(sys_rst))
		else $error("pin sampled at wrong time");
	vec_osc_a: assert property (@(posedge clk) disable iff (srst) // RQ7
		wait_end && pin_sync_r && osc_pend_r && !osc_fail |=> vec_sel == VEC_OSC && !osc_pend_r)
		else $error("oscillator vector not chosen");
	hold_rst_a: assert property (@(posedge clk) disable iff (srst) // RQ8
		state_r == ST_HOLD && pin_low |=> sys_rst && state_r == ST_HOLD)
		else $error("internal reset dropped while pin low");
	lock_flag_a: assert property (@(posedge clk) disable iff (srst) // RQ12
		lock_chg |=> flg_r.lock_chg ##1 flg_r.lock_chg || $past(wr_flg && pwdata[0]))
		else $error("lock change flag not set");
	lock_clr_a: assert property (@(posedge clk) disable iff (srst) // RQ15
		lock_clr && !flg_r.lock_chg && !wr_flg |=> !freq_lock_status_r && !flg_r.lock_chg)
		else $error("lock clear set the flag");
	irq_gate_a: assert property (@(posedge clk) disable iff (srst) // RQ11
		cpu_irq_mask || mask_r == 5'h00 |=> !irq)
		else $error("masked interrupt raised");

endmodule : crs_sequencer

`default_nettype wire

// File: sim/crs_pin_model.sv
// Reset pin load: pull-up plus an optional external holder.
// Assumes the design pulls the pin low only while rst_pin_oe is high.
`timescale 1ns/1ps
`default_nettype none
module crs_pin_model (
	input  wire logic rst_pin_out,
	input  wire logic rst_pin_oe,
	input  wire logic ext_low,
	output wire logic rst_pin_in
);
	// Light load: a released pin reads high at once unless ext_low holds it low
	assign rst_pin_in = rst_pin_oe ? rst_pin_out : !ext_low;
endmodule : crs_pin_model
`default_nettype wire

// File: sim/crs_sequencer_bench.sv
// Bench for crs_sequencer: APB master, reset events, lock interrupt.
// Assumes the crs_pkg register map and a pulled-up reset pin.
`timescale 1ns/1ps
`default_nettype none
module crs_sequencer_bench
	import crs_pkg::*;
;
	logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        por_det = 1'b0, illegal_acc = 1'b0, wdog_timeout = 1'b0, ext_low = 1'b0;
	logic        osc_clk_lost = 1'b0, osc_freq_low = 1'b0, osc_started = 1'b1;
	logic        lock_det = 1'b0, stop_entry = 1'b0, loop_cfg_wr = 1'b0, cpu_irq_mask = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
	logic [1:0]  vec_sel;
	logic        pready, pslverr, rst_pin_in, rst_pin_out, rst_pin_oe, sys_rst;
	logic        vec_valid, osc_enable, irq, rerr;
	int          n_mismatch = 0, checks_done = 0, k;
	integer      seed = 81279;
	// Selectors for the bounded level wait
	localparam int W_OE = 0, W_VEC = 1, W_RST = 2;

	always #20 clk = ~clk;

	crs_sequencer crs_sequencer_i (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .por_det(por_det), .illegal_acc(illegal_acc),
		.wdog_timeout(wdog_timeout), .osc_clk_lost(osc_clk_lost), .osc_freq_low(osc_freq_low),
		.osc_started(osc_started), .lock_det(lock_det), .stop_entry(stop_entry),
		.loop_cfg_wr(loop_cfg_wr), .cpu_irq_mask(cpu_irq_mask), .rst_pin_in(rst_pin_in),
		.rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .sys_rst(sys_rst),
		.vec_sel(vec_sel), .vec_valid(vec_valid), .osc_enable(osc_enable), .irq(irq));
	crs_pin_model crs_pin_model_i (.rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
		.ext_low(ext_low), .rst_pin_in(rst_pin_in));

	task automatic tally_and_finish();
		if (n_mismatch == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	function automatic logic level_of(input int sel);
		if (sel == W_OE)
			return rst_pin_oe;
		if (sel == W_VEC)
			return vec_valid;
		return sys_rst;
	endfunction : level_of

	// Bounded wait on a level; k ends as the cycles spent, a timeout ends the run
	task automatic hold_while(input int sel, input logic v, input int lim);
		k = 0;
		while (level_of(sel) === v && k < lim) begin
			@(negedge clk);
			k++;
		end
		if (level_of(sel) === v) begin
			n_mismatch++;
			$display("MISMATCH wait_%0d expected change by %0d seen %0d", sel, lim, k);
			tally_and_finish();
		end
	endtask : hold_while

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// Read right at the edge, before the design's own updates land
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_mismatch++;
			$display("MISMATCH pready expected 1 seen %b", pready);
			tally_and_finish();
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	function automatic logic [1:0] exp_vec(input logic pin, input logic osc, input logic wd);
		if (pin && osc)
			return VEC_OSC;
		if (pin && wd)
			return VEC_WDOG;
		return VEC_POR;
	endfunction : exp_vec

	task automatic measure(input logic [1:0] ev, input logic hold);
		cyc(1);
		hold_while(W_OE, 1'b0, 50);
		chk("pin_out", 32'h0000_0000, {31'h0, rst_pin_out});
		hold_while(W_OE, 1'b1, 600);
		chk("drive_len", 32'(DRIVE_CYC), k);
		hold_while(W_VEC, 1'b0, 400);
		chk("wait_len", 32'(WAIT_CYC), k);
		chk("vec_sel", {30'h0, ev}, {30'h0, vec_sel});
		chk("sys_rst", {31'h0, hold}, {31'h0, sys_rst});
		if (hold) begin
			@(posedge clk);
			ext_low <= 1'b0;
			hold_while(W_RST, 1'b1, 20);
			chk("sys_rst_ext", 32'h0000_0000, {31'h0, sys_rst});
		end
	endtask : measure

	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		cyc(1);
		hold_while(W_VEC, 1'b0, 900);
		chk("vec_por", {30'h0, exp_vec(1'b1, 1'b0, 1'b0)}, {30'h0, vec_sel});
		chk("sys_rst_por", 32'h0000_0000, {31'h0, sys_rst});
		apb(1'b1, ADDR_FLG, 32'h0000_0000);
		rd(ADDR_FLG);
		chk("flags_keep", 32'h0000_0002, rdat & 32'h0000_001f);
		apb(1'b1, ADDR_FLG, 32'h0000_0002);
		rd(ADDR_FLG);
		chk("flags_clr", 32'h0000_0000, rdat & 32'h0000_001f);
		for (int i = 0; i < 3; i++) begin
			rd(ADDR_TEST0);
			chk("test0", 32'h0000_0000, rdat);
			rd(ADDR_TEST1);
			chk("test1", {24'h00_0000, TEST1_VAL}, rdat);
			apb(1'b1, ADDR_TEST0, $random(seed));
			apb(1'b1, ADDR_TEST1, $random(seed));
		end
		rd(8'h80);
		chk("unmapped", 32'h0000_0001, {31'h0, rerr});
		@(posedge clk);
		osc_clk_lost <= 1'b1;
		@(posedge clk);
		osc_clk_lost <= 1'b0;
		cyc(4);
		chk("osc_gated", 32'h0000_0000, {31'h0, rst_pin_oe});
		for (int kind = 0; kind < 6; kind++) begin
			if (kind == 3) begin
				apb(1'b1, ADDR_CTL, 32'h0000_0001);
				cyc(1);
				chk("osc_on", 32'h0000_0001, {31'h0, osc_enable});
			end
			repeat (2 + ($random(seed) & 7)) @(posedge clk);
			por_det <= (kind == 0);
			illegal_acc <= (kind == 1);
			wdog_timeout <= (kind inside {2, 3, 5});
			osc_freq_low <= (kind == 3);
			ext_low <= (kind >= 4);
			@(posedge clk);
			por_det <= 1'b0;
			illegal_acc <= 1'b0;
			wdog_timeout <= 1'b0;
			osc_freq_low <= 1'b0;
			ext_low <= (kind == 5);
			measure(exp_vec(kind != 5, kind == 3, kind inside {2, 3, 5}), kind == 5);
		end
		rd(ADDR_FLG);
		chk("evt_flags", 32'h0000_001e, rdat & 32'h0000_001e);
		apb(1'b1, ADDR_MASK, 32'h0000_0001);
		lock_det <= 1'b1;
		cyc(3);
		chk("irq_rise", 32'h0000_0001, {31'h0, irq});
		@(posedge clk);
		cpu_irq_mask <= 1'b1;
		cyc(3);
		chk("irq_gmask", 32'h0000_0000, {31'h0, irq});
		apb(1'b1, ADDR_FLG, 32'h0000_0001);
		cpu_irq_mask <= 1'b0;
		rd(ADDR_FLG);
		chk("lock_clr", 32'h0000_0100, rdat & 32'h0000_0101);
		@(posedge clk);
		lock_det <= 1'b0;
		loop_cfg_wr <= 1'b1;
		@(posedge clk);
		loop_cfg_wr <= 1'b0;
		rd(ADDR_FLG);
		chk("lock_cfg", 32'h0000_0000, rdat & 32'h0000_0101);
		apb(1'b1, ADDR_MASK, 32'h0000_0000);
		lock_det <= 1'b1;
		cyc(3);
		chk("irq_local", 32'h0000_0000, {31'h0, irq});
		tally_and_finish();
	end
endmodule : crs_sequencer_bench
`default_nettype wire
